/* inc/amrc_consts.vh */
// amrc_consts.vh: offsets, fields, reset values and timing counts of the mode/reset control block
// assumes: included by its bare name from the design file; 10 MHz core clock
`ifndef AMRC_CONSTS_VH
`define AMRC_CONSTS_VH

// register offsets (6-bit register address space)
`define AMRC_OFS_IFSEL 6'h0D
`define AMRC_OFS_MODE 6'h10
`define AMRC_OFS_RSTCMD 6'h24

// interface select fields
`define AMRC_IF_SPI_BIT 7
`define AMRC_IF_I2C_BIT 6
`define AMRC_IF_3WIRE_BIT 5
`define AMRC_IF_RESET 8'h00

// mode control fields
`define AMRC_MODE_SWFIRE_BIT 7
`define AMRC_MODE_RESET 8'h00

// reset/reload command bits
`define AMRC_CMD_RESET_BIT 6
`define AMRC_CMD_RELOAD_BIT 7

// mode select field encodings
`define AMRC_M_SLEEP 3'h0
`define AMRC_M_STANDBY 3'h1
`define AMRC_M_SNIFF 3'h2
`define AMRC_M_CONT 3'h5
`define AMRC_M_COMBO 3'h6
`define AMRC_M_BURST 3'h7

// i2c addresses by address select level
`define AMRC_I2C_ADDR_LO 7'h4C
`define AMRC_I2C_ADDR_HI 7'h6C

// timing: 10 MHz clock, heartbeat ~500 Hz, reset/reload busy 1 ms
`define AMRC_CLK_HZ 10000000
`define AMRC_HB_HZ 500
`define AMRC_HB_CYCLES (`AMRC_CLK_HZ / `AMRC_HB_HZ)
`define AMRC_BUSY_US 1000
`define AMRC_BUSY_CYCLES ((`AMRC_CLK_HZ / 1000000) * `AMRC_BUSY_US)
`define AMRC_SLEEP_HB_MAX 3
`define AMRC_BURST_CONT 8'hFF

`endif

/* rtl/amrc_ctrl.v */
// amrc_ctrl.v: software reset, otp reload, operating mode machine and host interface selection
// assumes: a serial slave front end delivers decoded register writes/reads on the core clock;
// otp memory, sample datapath and fifo are outside and talk through the strobes below
//
// How it works
// RQ1: writing bit 6 to register 0x24 runs a full power-on reset internally.
// RQ2: host leaves registers alone for 1 ms after a software reset.
// RQ3: host places the device in standby before reset or reload commands.
// RQ4: after software reset completes, address select pin is resampled for i2c address.
// RQ5: host i2c bring-up writes the recommended nine-step initialization sequence.
// RQ6: host spi bring-up reads 0x18, then writes 0x80 to 0x0D until readback matches.
// RQ7: spi bring-up continues with 0x0F, 0x10, 10 ms wait, four init writes.
// RQ8: bit 7 to 0x24 reloads otp registers; other locations keep contents.
// RQ9: after reload completes, address pin is resampled; host waits 1 ms.
// RQ10: sleep after power-on; sleep requests always accepted, done within three heartbeats.
// RQ11: standby runs main and heartbeat clocks; heartbeat about 500 Hz.
// RQ12: triggered bursts start only from standby.
// RQ13: host sets sleep or standby before writing other registers.
// RQ14: watch mode runs watch sampling only, no fifo, jumps to continuous on activity.
// RQ15: continuous mode sends samples to output registers or fifo when enabled.
// RQ16: combined mode runs watch and continuous sampling together.
// RQ17: burst produces programmed 1 to 254 samples, or runs continuously.
// RQ18: burst rate comes from standby rate field, output rate ignored.
// RQ19: burst trigger is the interrupt pin or a software write of 0x10 bit 7.
// RQ20: mode changes advance on the ~500 Hz tick; machine updates mode field itself.
// RQ21: both serial interfaces active after reset until one select bit is written.
// RQ22: host writes 0x80 to 0x0D for four-wire spi.
// RQ23: in continuous mode only mode control is writable; sleep/standby all writable.
// RQ24: any reset returns the spi three-wire setting to four-wire.
`include "amrc_consts.vh"

module amrc_ctrl (
  input wire clk_in,
  input wire reset_in,
  input wire wr_stb_in,
  input wire [5:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  input wire [5:0] rd_addr_in,
  output reg [7:0] rd_data_out,
  input wire address_select_pin_in,
  input wire interrupt_pin_in,
  input wire fire_src_pin_in,
  input wire activity_in,
  input wire fifo_enable_in,
  input wire [2:0] standby_rate_field_in,
  input wire [7:0] burst_count_in,
  input wire otp_done_in,
  output wire reg_write_ok_out,
  output reg otp_load_out,
  output reg soft_por_out,
  output reg busy_out,
  output reg [6:0] i2c_addr_out,
  output reg i2c_en_out,
  output reg spi_en_out,
  output reg spi_3wire_out,
  output reg [2:0] mode_select_field_out,
  output reg watch_run_out,
  output reg sample_run_out,
  output reg sample_to_fifo_out,
  output reg sample_stb_out,
  output reg [2:0] sample_rate_out,
  output reg hb_tick_out
);

  // ==========================================================
  // input synchronisers
  reg [1:0] addr_sync_ff;
  reg [1:0] int_sync_ff;
  reg int_prev_ff;
  wire int_rise = int_sync_ff[1] & ~int_prev_ff;

  // two flops on the address select and interrupt pins before use; fire_src_pin_in is used unsynchronised
  always @(posedge clk_in) begin
    if (reset_in) begin
      addr_sync_ff <= 2'h0;
      int_sync_ff <= 2'h0;
      int_prev_ff <= 1'b0;
    end else begin
      addr_sync_ff <= {addr_sync_ff[0], address_select_pin_in};
      int_sync_ff <= {int_sync_ff[0], interrupt_pin_in};
      int_prev_ff <= int_sync_ff[1];
    end
  end

  // ==========================================================
  // heartbeat divider
  localparam integer HB_LAST_I = `AMRC_HB_CYCLES - 1;
  localparam [15:0] HB_LAST = HB_LAST_I[15:0];
  reg [15:0] hb_cnt_ff;

  // one-cycle tick at ~500 Hz, runs in every mode but sleep too so sleep can settle
  always @(posedge clk_in) begin
    if (reset_in) begin
      hb_cnt_ff <= 16'h0000;
      hb_tick_out <= 1'b0;
    end else if (hb_cnt_ff == HB_LAST) begin
      hb_cnt_ff <= 16'h0000;
      hb_tick_out <= 1'b1; // RQ11
    end else begin
      hb_cnt_ff <= hb_cnt_ff + 16'h0001;
      hb_tick_out <= 1'b0;
    end
  end

  // ==========================================================
  // reset and reload sequencer
  localparam [1:0] SQ_IDLE = 2'h0;
  localparam [1:0] SQ_POR = 2'h1;
  localparam [1:0] SQ_LOAD = 2'h2;
  localparam [1:0] SQ_WAIT = 2'h3;
  localparam integer BUSY_LAST_I = `AMRC_BUSY_CYCLES - 1;
  localparam [13:0] BUSY_LAST = BUSY_LAST_I[13:0];

  reg [1:0] sq_state_ff;
  reg [13:0] busy_cnt_ff;
  reg sq_por_ff;
  reg addr_sample_ff;
  wire cmd_wr = wr_stb_in & reg_write_ok_out & (wr_addr_in == `AMRC_OFS_RSTCMD) & (sq_state_ff == SQ_IDLE);
  wire cmd_reset = cmd_wr & wr_data_in[`AMRC_CMD_RESET_BIT];
  wire cmd_reload = cmd_wr & wr_data_in[`AMRC_CMD_RELOAD_BIT] & ~wr_data_in[`AMRC_CMD_RESET_BIT];

  // soft por pulses the whole register set back, then a reload and a 1 ms busy window follow
  always @(posedge clk_in) begin
    if (reset_in) begin
      sq_state_ff <= SQ_POR;
      busy_cnt_ff <= 14'h0000;
      sq_por_ff <= 1'b1;
      soft_por_out <= 1'b0;
      otp_load_out <= 1'b0;
      busy_out <= 1'b1;
      addr_sample_ff <= 1'b0;
    end else begin
      soft_por_out <= 1'b0;
      otp_load_out <= 1'b0;
      addr_sample_ff <= 1'b0;
      case (sq_state_ff)
        SQ_IDLE: begin
          busy_out <= 1'b0;
          if (cmd_reset) begin
            sq_state_ff <= SQ_POR; // RQ1
            sq_por_ff <= 1'b1;
            soft_por_out <= 1'b1;
            busy_out <= 1'b1;
          end else if (cmd_reload) begin
            sq_state_ff <= SQ_LOAD; // RQ8
            sq_por_ff <= 1'b0;
            otp_load_out <= 1'b1;
            busy_out <= 1'b1;
          end
        end
        SQ_POR: begin
          sq_state_ff <= SQ_LOAD;
          otp_load_out <= 1'b1;
        end
        SQ_LOAD: begin
          if (otp_done_in) begin
            sq_state_ff <= SQ_WAIT;
            busy_cnt_ff <= 14'h0000;
            addr_sample_ff <= 1'b1; // RQ4 RQ9
          end
        end
        SQ_WAIT: begin
          if (busy_cnt_ff == BUSY_LAST) begin
            sq_state_ff <= SQ_IDLE; // RQ2
            busy_out <= 1'b0;
          end else begin
            busy_cnt_ff <= busy_cnt_ff + 14'h0001;
          end
        end
        default: begin
          sq_state_ff <= SQ_IDLE;
        end
      endcase
    end
  end

  // i2c address follows the synchronised pin level after each reset or reload
  always @(posedge clk_in) begin
    if (reset_in) begin
      i2c_addr_out <= `AMRC_I2C_ADDR_LO;
    end else if (addr_sample_ff) begin
      i2c_addr_out <= addr_sync_ff[1] ? `AMRC_I2C_ADDR_HI : `AMRC_I2C_ADDR_LO; // RQ4 RQ9
    end
  end

  // ==========================================================
  // register write gating
  wire in_cont = (mode_select_field_out == `AMRC_M_CONT);
  wire quiet_mode = (mode_select_field_out == `AMRC_M_SLEEP) | (mode_select_field_out == `AMRC_M_STANDBY);

  // continuous mode takes only mode control; other active modes likewise; sleep/standby take all
  assign reg_write_ok_out = ~busy_out & (quiet_mode | (wr_addr_in == `AMRC_OFS_MODE)); // RQ23

  wire wr_mode = wr_stb_in & reg_write_ok_out & (wr_addr_in == `AMRC_OFS_MODE);
  wire wr_ifsel = wr_stb_in & reg_write_ok_out & (wr_addr_in == `AMRC_OFS_IFSEL);
  wire por_clear = soft_por_out;

  // ==========================================================
  // interface select
  reg if_chosen_ff;

  // both interfaces live until a write sets exactly one select bit; three-wire falls back on any reset
  always @(posedge clk_in) begin
    if (reset_in || por_clear) begin
      i2c_en_out <= 1'b1; // RQ21
      spi_en_out <= 1'b1;
      spi_3wire_out <= 1'b0; // RQ24
      if_chosen_ff <= 1'b0;
    end else if (wr_ifsel) begin
      spi_3wire_out <= wr_data_in[`AMRC_IF_3WIRE_BIT] & wr_data_in[`AMRC_IF_SPI_BIT];
      if (wr_data_in[`AMRC_IF_SPI_BIT] ^ wr_data_in[`AMRC_IF_I2C_BIT]) begin
        i2c_en_out <= wr_data_in[`AMRC_IF_I2C_BIT]; // RQ21
        spi_en_out <= wr_data_in[`AMRC_IF_SPI_BIT];
        if_chosen_ff <= 1'b1;
      end
    end
  end

  // ==========================================================
  // mode state machine
  reg [2:0] req_mode_ff;
  reg req_pend_ff;
  reg [1:0] sleep_wait_ff;
  reg sw_fire_ff;
  reg burst_arm_ff;
  reg [7:0] burst_left_ff;
  reg burst_cont_ff;
  reg [7:0] mode_ctrl_ff;
  reg [2:0] nxt_mode;

  wire fire_now = burst_arm_ff & (fire_src_pin_in ? int_rise : sw_fire_ff); // RQ19

  // accepted requests wait for the heartbeat; sleep settles on the third tick
  always @(posedge clk_in) begin
    if (reset_in || por_clear) begin
      mode_select_field_out <= `AMRC_M_SLEEP; // RQ10
      req_mode_ff <= `AMRC_M_SLEEP;
      req_pend_ff <= 1'b0;
      sleep_wait_ff <= 2'h0;
      sw_fire_ff <= 1'b0;
      burst_arm_ff <= 1'b0;
      burst_left_ff <= 8'h00;
      burst_cont_ff <= 1'b0;
      mode_ctrl_ff <= `AMRC_MODE_RESET;
    end else begin
      if (wr_mode) begin
        mode_ctrl_ff <= wr_data_in;
        req_mode_ff <= wr_data_in[2:0];
        req_pend_ff <= 1'b1;
        sleep_wait_ff <= 2'h0;
        if (wr_data_in[`AMRC_MODE_SWFIRE_BIT]) begin
          sw_fire_ff <= 1'b1; // RQ19
        end
      end else if (fire_now) begin
        sw_fire_ff <= 1'b0;
      end
      if (hb_tick_out) begin
        mode_select_field_out <= nxt_mode; // RQ20
        mode_ctrl_ff[2:0] <= nxt_mode;
        if (req_pend_ff && !wr_mode) begin
          if (req_mode_ff != `AMRC_M_SLEEP || sleep_wait_ff == (`AMRC_SLEEP_HB_MAX - 1)) begin
            req_pend_ff <= 1'b0;
          end else begin
            sleep_wait_ff <= sleep_wait_ff + 2'h1; // RQ10
          end
        end
        if (nxt_mode == `AMRC_M_BURST && mode_select_field_out == `AMRC_M_STANDBY) begin
          burst_arm_ff <= 1'b1; // RQ12
          burst_cont_ff <= (burst_count_in == `AMRC_BURST_CONT) | (burst_count_in == 8'h00);
          burst_left_ff <= burst_count_in;
        end else if (nxt_mode != `AMRC_M_BURST) begin
          burst_arm_ff <= 1'b0;
        end
      end
      if (sample_stb_out && mode_select_field_out == `AMRC_M_BURST && !burst_cont_ff) begin
        burst_left_ff <= burst_left_ff - 8'h01; // RQ17
      end
    end
  end

  // next mode: requests, activity wake-up, burst completion returns to standby
  always @* begin
    nxt_mode = mode_select_field_out;
    if (req_pend_ff) begin
      if (req_mode_ff == `AMRC_M_BURST) begin
        if (mode_select_field_out == `AMRC_M_STANDBY) begin
          nxt_mode = `AMRC_M_BURST; // RQ12
        end
      end else if (req_mode_ff == `AMRC_M_SLEEP) begin
        if (sleep_wait_ff == (`AMRC_SLEEP_HB_MAX - 1)) begin
          nxt_mode = `AMRC_M_SLEEP; // RQ10
        end
      end else begin
        nxt_mode = req_mode_ff;
      end
    end else if (mode_select_field_out == `AMRC_M_SNIFF && activity_in) begin
      nxt_mode = `AMRC_M_CONT; // RQ14
    end else if (mode_select_field_out == `AMRC_M_BURST && !burst_cont_ff && burst_left_ff == 8'h00) begin
      nxt_mode = `AMRC_M_STANDBY; // RQ17
    end
  end

  // ==========================================================
  // sampling controls
  reg [7:0] rate_div_ff;
  reg burst_go_ff;

  // burst paces on the standby rate field: 2^rate heartbeats per sample
  always @(posedge clk_in) begin
    if (reset_in || por_clear) begin
      rate_div_ff <= 8'h00;
      burst_go_ff <= 1'b0;
      sample_stb_out <= 1'b0;
    end else begin
      sample_stb_out <= 1'b0;
      if (mode_select_field_out != `AMRC_M_BURST) begin
        burst_go_ff <= 1'b0;
        rate_div_ff <= 8'h00;
      end else begin
        if (fire_now) begin
          burst_go_ff <= 1'b1; // RQ19
        end
        if (burst_go_ff && hb_tick_out && (burst_cont_ff || burst_left_ff != 8'h00)) begin
          if (rate_div_ff == ((8'h01 << standby_rate_field_in) - 8'h01)) begin
            rate_div_ff <= 8'h00;
            sample_stb_out <= 1'b1; // RQ18
          end else begin
            rate_div_ff <= rate_div_ff + 8'h01;
          end
        end
      end
    end
  end

  // run enables for the watch circuit and the xyz path per mode
  always @(posedge clk_in) begin
    if (reset_in || por_clear) begin
      watch_run_out <= 1'b0;
      sample_run_out <= 1'b0;
      sample_to_fifo_out <= 1'b0;
      sample_rate_out <= 3'h0;
    end else begin
      watch_run_out <= (mode_select_field_out == `AMRC_M_SNIFF) | (mode_select_field_out == `AMRC_M_COMBO); // RQ14 RQ16
      sample_run_out <= in_cont | (mode_select_field_out == `AMRC_M_COMBO) | burst_go_ff; // RQ15 RQ16
      sample_to_fifo_out <= fifo_enable_in & (mode_select_field_out != `AMRC_M_SNIFF); // RQ14 RQ15
      sample_rate_out <= standby_rate_field_in; // RQ18
    end
  end

  // ==========================================================
  // read-back of the block's own registers
  always @* begin
    case (rd_addr_in)
      `AMRC_OFS_IFSEL: rd_data_out = {spi_en_out & if_chosen_ff, i2c_en_out & if_chosen_ff, spi_3wire_out, 5'h00};
      `AMRC_OFS_MODE: rd_data_out = {1'b0, mode_ctrl_ff[6:3], mode_select_field_out};
      default: rd_data_out = 8'h00;
    endcase
  end

endmodule

/* tb/amrc_ctrl_checker.sv */
// amrc_ctrl_checker.sv: port assertions for the mode and reset control block
// assumes: bound to amrc_ctrl, one clock domain, sync active-high reset
`include "amrc_consts.vh"
module amrc_checker (
  input wire clk_in,
  input wire reset_in,
  input wire wr_stb_in,
  input wire [5:0] wr_addr_in,
  input wire [7:0] wr_data_in,
  input wire reg_write_ok_out,
  input wire otp_load_out,
  input wire soft_por_out,
  input wire busy_out,
  input wire i2c_en_out,
  input wire spi_en_out,
  input wire spi_3wire_out,
  input wire [2:0] mode_select_field_out,
  input wire watch_run_out,
  input wire sample_run_out,
  input wire hb_tick_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // heartbeat gap counter, restarted by reset_in and by each tick
  logic [15:0] gap_ff;
  logic seen_ff;
  always_ff @(posedge clk_in) begin
    gap_ff <= (reset_in || hb_tick_out) ? 16'h0000 : gap_ff + 16'h0001;
    seen_ff <= !reset_in && !soft_por_out && (seen_ff || hb_tick_out);
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================
  // properties
  chk_cmd_reset: assert property (wr_stb_in && reg_write_ok_out && wr_addr_in == `AMRC_OFS_RSTCMD &&
    wr_data_in[6] |=> soft_por_out) else $error("reset command gave no reset pulse");
  chk_por_seq: assert property (soft_por_out |-> busy_out ##1 otp_load_out)
    else $error("reset pulse not followed by busy and load");
  chk_cmd_reload: assert property (wr_stb_in && reg_write_ok_out && wr_addr_in == `AMRC_OFS_RSTCMD &&
    wr_data_in[7:6] == 2'b10 |=> otp_load_out && !soft_por_out) else $error("reload command misbehaved");
  chk_busy_refuse: assert property (busy_out |-> !reg_write_ok_out)
    else $error("write accepted while busy");
  chk_por_clear: assert property (soft_por_out ##2 busy_out |-> i2c_en_out && spi_en_out &&
    !spi_3wire_out && mode_select_field_out == `AMRC_M_SLEEP) else $error("reset left state behind");
  chk_mode_tick: assert property ($changed(mode_select_field_out) && !busy_out |->
    hb_tick_out || $past(hb_tick_out)) else $error("mode changed off the heartbeat");
  chk_hb_period: assert property (hb_tick_out && seen_ff |-> gap_ff == 16'h4E1F)
    else $error("heartbeat period wrong");
  chk_cont_run: assert property (mode_select_field_out == `AMRC_M_CONT [*2] |->
    sample_run_out && !watch_run_out) else $error("continuous mode not sampling");
  chk_watch_run: assert property (mode_select_field_out == `AMRC_M_SNIFF [*2] |->
    watch_run_out && !sample_run_out) else $error("watch mode running wrong paths");
  chk_cont_write: assert property (mode_select_field_out == `AMRC_M_CONT &&
    wr_addr_in != `AMRC_OFS_MODE |-> !reg_write_ok_out) else $error("write allowed in continuous mode");
endmodule
bind amrc_ctrl amrc_checker u_chk (.clk_in, .reset_in, .wr_stb_in, .wr_addr_in, .wr_data_in,
  .reg_write_ok_out, .otp_load_out, .soft_por_out, .busy_out, .i2c_en_out, .spi_en_out,
  .spi_3wire_out, .mode_select_field_out, .watch_run_out, .sample_run_out, .hb_tick_out);

/* tb/amrc_host_model.sv */
// amrc_host_model.sv: host that issues decoded register writes and reads
// assumes: same clock as the block; changes its outputs just after rising edges
module amrc_host_model (
  input wire clk_in,
  input wire busy_in,
  input wire [7:0] rd_data_in,
  output logic wr_stb_out = 1'b0,
  output logic [5:0] wr_addr_out = 6'h00,
  output logic [7:0] wr_data_out = 8'h00,
  output logic [5:0] rd_addr_out = 6'h00
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // one write: stay off the registers while busy, then a one-cycle strobe
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk_in); // busy is looked at settled, never in the edge that launches it
    while (busy_in !== 1'b0) @(negedge clk_in);
    @(posedge clk_in);
    wr_stb_out <= 1'b1;
    wr_addr_out <= a;
    wr_data_out <= d;
    @(posedge clk_in);
    wr_stb_out <= 1'b0;
  endtask
  // one read: read data is combinational, taken mid-cycle
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk_in);
    rd_addr_out <= a;
    @(negedge clk_in);
    d = rd_data_in;
  endtask
endmodule

/* tb/amrc_ctrl_tb.sv */
// amrc_ctrl_tb.sv: self-checking bench for the mode and reset control block
// assumes: amrc_ctrl, the host model and the bound checker are compiled with it
`include "amrc_consts.vh"
module amrc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic address_select_pin_in = 1'b0;
  logic activity_in = 1'b0;
  logic fifo_enable_in = 1'b0;
  logic otp_done_in = 1'b0;
  logic [7:0] d;
  int n_fail = 0;
  int total_checks = 0;
  wire wr_stb_in, reg_write_ok_out, otp_load_out, soft_por_out, busy_out, i2c_en_out, spi_en_out;
  wire spi_3wire_out, watch_run_out, sample_run_out, sample_to_fifo_out, sample_stb_out, hb_tick_out;
  wire [5:0] wr_addr_in, rd_addr_in;
  wire [7:0] wr_data_in, rd_data_out;
  wire [6:0] i2c_addr_out;
  wire [2:0] mode_select_field_out, sample_rate_out;
  // ==========================================
  // clock, otp loader answering each load pulse, instances
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) otp_done_in <= otp_load_out;
  amrc_ctrl DUT (.clk_in, .reset_in, .wr_stb_in, .wr_addr_in, .wr_data_in, .rd_addr_in, .rd_data_out,
    .address_select_pin_in, .interrupt_pin_in(1'b0), .fire_src_pin_in(1'b0), .activity_in,
    .fifo_enable_in, .standby_rate_field_in(3'h0), .burst_count_in(8'h03), .otp_done_in,
    .reg_write_ok_out, .otp_load_out, .soft_por_out, .busy_out, .i2c_addr_out, .i2c_en_out,
    .spi_en_out, .spi_3wire_out, .mode_select_field_out, .watch_run_out, .sample_run_out,
    .sample_to_fifo_out, .sample_stb_out, .sample_rate_out, .hb_tick_out);
  amrc_host_model host (.clk_in, .busy_in(busy_out), .rd_data_in(rd_data_out), .wr_stb_out(wr_stb_in),
    .wr_addr_out(wr_addr_in), .wr_data_out(wr_data_in), .rd_addr_out(rd_addr_in));
  // ==========================================
  // shared helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wait_tick;
    int i;
    @(negedge clk_in);
    for (i = 0; i < 20010 && hb_tick_out !== 1'b1; i++) @(negedge clk_in);
    repeat (2) @(negedge clk_in);
  endtask
  task automatic wait_idle(output int n);
    for (n = 0; n < 20000 && busy_out !== 1'b0; n++) @(negedge clk_in);
  endtask
  task automatic watch_cmd(output logic lp, output logic sp);
    lp = 1'b0;
    sp = 1'b0;
    repeat (4) begin
      @(negedge clk_in);
      lp |= otp_load_out;
      sp |= soft_por_out;
    end
  endtask
  // ==========================================
  // scenarios
  // closing writes of both bring-up sequences, all to registers outside this block
  task automatic init_tail;
    host.wr(6'h20, 8'h01);
    host.wr(6'h21, 8'h80);
    host.wr(6'h28, 8'h00);
    host.wr(6'h1A, 8'h00);
  endtask
  task automatic t_reset;
    int n;
    @(negedge clk_in);
    check({i2c_en_out, spi_en_out, spi_3wire_out, busy_out}, 8'h0D);
    check(i2c_addr_out, `AMRC_I2C_ADDR_LO);
    check(mode_select_field_out, `AMRC_M_SLEEP);
    repeat (9) @(posedge clk_in);
    reset_in <= 1'b0;
    for (n = 0; n < 10 && otp_done_in !== 1'b1; n++) @(negedge clk_in);
    check(otp_done_in, 8'h01);
    wait_idle(n);
    check(n >= `AMRC_BUSY_CYCLES - 1 && n <= `AMRC_BUSY_CYCLES + 3, 8'h01);
  endtask
  task automatic t_ifsel;
    int n;
    host.rd(6'h18, d);
    for (n = 0; n < 4 && d !== 8'h80; n++) begin
      host.wr(`AMRC_OFS_IFSEL, 8'h80);
      host.rd(`AMRC_OFS_IFSEL, d);
    end
    check(d, 8'h80);
    check({i2c_en_out, spi_en_out, spi_3wire_out}, 8'h02);
    host.wr(`AMRC_OFS_IFSEL, 8'hC0); // both bits: refused
    repeat (2) @(negedge clk_in);
    check({i2c_en_out, spi_en_out}, 8'h01);
    host.wr(`AMRC_OFS_IFSEL, 8'hA0);
    repeat (2) @(negedge clk_in);
    check(spi_3wire_out, 8'h01);
  endtask
  task automatic t_standby;
    host.wr(6'h0F, 8'h42);
    host.wr(`AMRC_OFS_MODE, {5'h00, `AMRC_M_STANDBY});
    // this block settles on the next heartbeat, so the long settling wait is cut short
    wait_tick;
    check(mode_select_field_out, `AMRC_M_STANDBY);
    init_tail;
    host.rd(`AMRC_OFS_MODE, d);
    check(d, {5'h00, `AMRC_M_STANDBY});
  endtask
  task automatic t_reload;
    int n;
    logic lp, sp;
    host.wr(`AMRC_OFS_RSTCMD, 8'h80);
    watch_cmd(lp, sp);
    check({lp, sp}, 8'h02);
    check(reg_write_ok_out, 8'h00);
    wait_idle(n);
    check(mode_select_field_out, `AMRC_M_STANDBY);
  endtask
  task automatic t_softrst;
    int n;
    logic lp, sp;
    @(posedge clk_in);
    address_select_pin_in <= 1'b1;
    host.wr(`AMRC_OFS_MODE, {5'h00, `AMRC_M_STANDBY});
    host.wr(`AMRC_OFS_RSTCMD, 8'h40);
    watch_cmd(lp, sp);
    check({lp, sp}, 8'h03);
    wait_idle(n);
    repeat (2) @(negedge clk_in);
    check(i2c_addr_out, `AMRC_I2C_ADDR_HI);
    check({i2c_en_out, spi_en_out, spi_3wire_out}, 8'h06);
    check(mode_select_field_out, `AMRC_M_SLEEP);
    host.rd(`AMRC_OFS_IFSEL, d);
    check(d, `AMRC_IF_RESET);
    host.wr(`AMRC_OFS_IFSEL, 8'h40);
    host.wr(6'h0F, 8'h42);
    init_tail;
    host.rd(`AMRC_OFS_IFSEL, d);
    check(d, 8'h40);
  endtask
  task automatic t_watch;
    host.wr(`AMRC_OFS_MODE, {5'h00, `AMRC_M_SNIFF});
    wait_tick;
    check({mode_select_field_out, watch_run_out, sample_run_out, sample_to_fifo_out}, 8'h14);
    @(posedge clk_in);
    activity_in <= 1'b1;
    fifo_enable_in <= 1'b1;
    wait_tick;
    check({mode_select_field_out, watch_run_out, sample_run_out, sample_to_fifo_out}, 8'h2B);
    host.wr(`AMRC_OFS_IFSEL, 8'h80); // refused in continuous mode
    host.rd(`AMRC_OFS_IFSEL, d);
    check(d, 8'h40);
  endtask
  // ==========================================
  // verdict, main sequence and watchdog
  task automatic report_and_stop;
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    t_reset;
    t_ifsel;
    t_standby;
    t_reload;
    t_softrst;
    t_watch;
    report_and_stop;
  end
  initial begin
    repeat (95000) @(posedge clk_in);
    n_fail++;
    report_and_stop;
  end
endmodule
